// ### hw/csoc_params.svh
`ifndef CSOC_PARAMS_SVH
`define CSOC_PARAMS_SVH
// Register byte address
`define CSOC_CTRL_ADDR 12'h000
// Field positions in the control register
`define CSOC_ENABLE_BIT 7
`define CSOC_REFMODE_BIT 6
`define CSOC_RANGE_HI 3
`define CSOC_RANGE_LO 2
`define CSOC_DRIVE_BIT 1
`define CSOC_EXTPICK_BIT 0
// Reset value and writable bits
`define CSOC_CTRL_RESET 8'h00
`define CSOC_CTRL_WMASK 8'hcd
// Range codes
`define CSOC_RANGE_OFF 2'h0
`define CSOC_RANGE_LOW 2'h1
`define CSOC_RANGE_MED 2'h2
`define CSOC_RANGE_HIGH 2'h3
`endif

// ### hw/csoc_pkg.sv
package csoc_pkg;
  // Drive level handed to the analog current source
  typedef enum logic [1:0] {
    CSOC_CUR_NONE,
    CSOC_CUR_LOW,
    CSOC_CUR_MED,
    CSOC_CUR_HIGH
  } csoc_cur_e;
endpackage

// ### hw/csoc_ctrl.sv
`timescale 1ns/1ps
`include "csoc_params.svh"
module csoc_ctrl (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator and sleep
  input wire logic osc_clk_in,
  input wire logic sleep_mode,
  input wire logic timer_zero_clock_select,
  input wire logic timer_zero_clock_pin,
  // Analog and timer controls
  output logic osc_run,
  output logic reference_mode_out,
  output logic noise_detect,
  output csoc_pkg::csoc_cur_e current_level,
  output logic timer_zero_count_tick,
  output logic osc_count_tick
);

  ////////////////////////////////////////////////////////////////////////
  // Control register
  logic [7:0] ctrl_q, ctrl_d; // Writable bits only; bit 1 never stored
  logic acc; // Access phase of a transfer to us
  logic hit; // Address matches the control register

  // Pin synchronisers: two flops each before any logic looks
  logic [1:0] osc_sync_q, osc_sync_d;
  logic [1:0] pin_sync_q, pin_sync_d;
  logic osc_prev_q, osc_prev_d; // Last synchronised oscillator level
  logic pin_prev_q, pin_prev_d; // Last synchronised pin level
  logic osc_rise, pin_rise;
  logic drive_state;
  logic [31:0] prdata_d; // Next read data, loaded only in setup

  assign acc = psel && penable;
  assign hit = paddr == `CSOC_CTRL_ADDR;
  // Ready follows the clock enable, so a frozen block stretches
  // the access instead of dropping it; unmapped address errors
  assign pready = pclken;
  assign pslverr = acc && !hit;

  // Next control value
  always_comb begin
    ctrl_d = ctrl_q;
    if (acc && pwrite && hit) begin
      // Bit 0 stored regardless of clock select
      ctrl_d = pwdata[7:0] & `CSOC_CTRL_WMASK;
    end
  end

  // Next read data; captured in setup so it already stands in access
  always_comb begin
    prdata_d = prdata;
    if (psel && !penable && !pwrite && hit) begin
      prdata_d = {24'h00_0000, ctrl_q[7:2], drive_state, ctrl_q[0]};
    end else if (psel && !penable) begin
      // Unmapped or write setup reads back zero
      prdata_d = 32'h0000_0000;
    end
  end

  // Registers; clock enable freezes all state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CSOC_CTRL_RESET;
      osc_sync_q <= 2'h0;
      pin_sync_q <= 2'h0;
      osc_prev_q <= 1'b0;
      pin_prev_q <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (pclken) begin
      ctrl_q <= ctrl_d;
      osc_sync_q <= osc_sync_d;
      pin_sync_q <= pin_sync_d;
      osc_prev_q <= osc_prev_d;
      pin_prev_q <= pin_prev_d;
      prdata <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers and edge detection
  always_comb begin
    osc_sync_d = {osc_sync_q[0], osc_clk_in};
    pin_sync_d = {pin_sync_q[0], timer_zero_clock_pin};
    osc_prev_d = osc_sync_q[1];
    pin_prev_d = pin_sync_q[1];
  end

  assign osc_rise = osc_sync_q[1] && !osc_prev_q;
  assign pin_rise = pin_sync_q[1] && !pin_prev_q;
  // High while sourcing current out of the pad
  assign drive_state = osc_sync_q[1] && osc_run;

  ////////////////////////////////////////////////////////////////////////
  // Analog control decode
  always_comb begin
    // Running is independent of sleep
    osc_run = ctrl_q[`CSOC_ENABLE_BIT];
    reference_mode_out = ctrl_q[`CSOC_REFMODE_BIT];
    noise_detect = 1'b0;
    current_level = csoc_pkg::CSOC_CUR_NONE;
    if (osc_run) begin
      case (ctrl_q[`CSOC_RANGE_HI:`CSOC_RANGE_LO])
        `CSOC_RANGE_OFF: noise_detect = ctrl_q[`CSOC_REFMODE_BIT];
        `CSOC_RANGE_LOW: current_level = csoc_pkg::CSOC_CUR_LOW;
        `CSOC_RANGE_MED: current_level = csoc_pkg::CSOC_CUR_MED;
        `CSOC_RANGE_HIGH: current_level = csoc_pkg::CSOC_CUR_HIGH;
        default: current_level = csoc_pkg::CSOC_CUR_NONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count ticks toward the timers
  always_comb begin
    // Free-running tick for any sleep-capable timer
    osc_count_tick = osc_rise && osc_run;
    timer_zero_count_tick = 1'b0;
    // First timer gets nothing while asleep
    if (!sleep_mode && timer_zero_clock_select) begin
      if (ctrl_q[`CSOC_EXTPICK_BIT]) begin
        timer_zero_count_tick = osc_rise && osc_run;
      end else begin
        timer_zero_count_tick = pin_rise;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_sleep_halts;
    @(posedge pclk) disable iff (!presetn) sleep_mode |-> !timer_zero_count_tick;
  endproperty
  a_sleep_halts: assert property (p_sleep_halts) else $error("first timer ticked in sleep");

  property p_run_enable;
    @(posedge pclk) disable iff (!presetn) osc_run == ctrl_q[7];
  endproperty
  a_run_enable: assert property (p_run_enable) else $error("run not following enable");

  property p_write_enable;
    @(posedge pclk) disable iff (!presetn)
      (pclken && acc && pwrite && hit) |=> (osc_run == $past(pwdata[7]));
  endproperty
  a_write_enable: assert property (p_write_enable) else $error("enable write lost");

  property p_noise;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_q[7:6] == 2'h3 && ctrl_q[3:2] == 2'h0) |-> (noise_detect && current_level == csoc_pkg::CSOC_CUR_NONE);
  endproperty
  a_noise: assert property (p_noise) else $error("noise mode wrong");

  property p_fixed_off;
    @(posedge pclk) disable iff (!presetn) !ctrl_q[6] |-> !noise_detect;
  endproperty
  a_fixed_off: assert property (p_fixed_off) else $error("noise in fixed mode");

  property p_range;
    @(posedge pclk) disable iff (!presetn) osc_run |-> (current_level == ctrl_q[3:2]);
  endproperty
  a_range: assert property (p_range) else $error("range decode wrong");

  property p_pin_src;
    @(posedge pclk) disable iff (!presetn)
      (timer_zero_clock_select && !sleep_mode && !ctrl_q[0]) |-> (timer_zero_count_tick == pin_rise);
  endproperty
  a_pin_src: assert property (p_pin_src) else $error("pin clock not chosen");

  property p_internal;
    @(posedge pclk) disable iff (!presetn) !timer_zero_clock_select |-> !timer_zero_count_tick;
  endproperty
  a_internal: assert property (p_internal) else $error("bit 0 acted on internal clock");

  property p_sleep_count;
    @(posedge pclk) disable iff (!presetn) (sleep_mode && osc_run && osc_rise) |-> osc_count_tick;
  endproperty
  a_sleep_count: assert property (p_sleep_count) else $error("count lost in sleep");

  property p_drive_ro;
    @(posedge pclk) disable iff (!presetn) !osc_run |-> !drive_state;
  endproperty
  a_drive_ro: assert property (p_drive_ro) else $error("drive state while off");

  ////////////////////////////////////////////////////////////////////////
  // Further checks on writes, reads and decode

  // Ready must track the enable or a frozen write is lost
  property p_ready_en;
    @(posedge pclk) disable iff (!presetn)
      pready == pclken;
  endproperty
  a_ready_en: assert property (p_ready_en) else $error("ready not following clock enable");

  // Status bit is never stored, whatever software writes
  property p_ro_bit;
    @(posedge pclk) disable iff (!presetn)
      (pclken && acc && pwrite && hit) |=> (ctrl_q[1] == 1'b0);
  endproperty
  a_ro_bit: assert property (p_ro_bit) else $error("status bit stored");

  // Unused bits stay clear so they read back zero
  property p_unused_zero;
    @(posedge pclk) disable iff (!presetn)
      ctrl_q[5:4] == 2'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

  // Mode bit written lands on the reference output
  property p_write_mode;
    @(posedge pclk) disable iff (!presetn)
      (pclken && acc && pwrite && hit) |=> (reference_mode_out == $past(pwdata[6]));
  endproperty
  a_write_mode: assert property (p_write_mode) else $error("mode write lost");

  // Range field written is kept as given
  property p_write_range;
    @(posedge pclk) disable iff (!presetn)
      (pclken && acc && pwrite && hit) |=> (ctrl_q[3:2] == $past(pwdata[3:2]));
  endproperty
  a_write_range: assert property (p_write_range) else $error("range write lost");

  // Pick bit stored even while the internal clock is chosen
  property p_write_pick;
    @(posedge pclk) disable iff (!presetn)
      (pclken && acc && pwrite && hit) |=> (ctrl_q[0] == $past(pwdata[0]));
  endproperty
  a_write_pick: assert property (p_write_pick) else $error("pick write lost");

  // Oscillator feeds the first timer when picked
  property p_osc_src;
    @(posedge pclk) disable iff (!presetn)
      (timer_zero_clock_select && !sleep_mode && ctrl_q[0]) |-> (timer_zero_count_tick == (osc_rise && osc_run));
  endproperty
  a_osc_src: assert property (p_osc_src) else $error("oscillator clock not chosen");

  // Disabled module drives no current, no noise flag and no oscillator ticks; pin ticks still reach the first timer
  property p_off_quiet;
    @(posedge pclk) disable iff (!presetn)
      !osc_run |-> (current_level == csoc_pkg::CSOC_CUR_NONE && !noise_detect && !osc_count_tick);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("activity while disabled");

  // Frozen clock enable keeps the register as it was
  property p_frozen;
    @(posedge pclk) disable iff (!presetn)
      !pclken |=> $stable(ctrl_q);
  endproperty
  a_frozen: assert property (p_frozen) else $error("register moved while frozen");

  // Unmapped access always flags an error
  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
      (acc && !hit) |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

  // Noise detection only for the zero range code
  property p_var_current;
    @(posedge pclk) disable iff (!presetn)
      (osc_run && ctrl_q[6] && ctrl_q[3:2] != 2'h0) |-> !noise_detect;
  endproperty
  a_var_current: assert property (p_var_current) else $error("noise mode with current range");

  // Setup of a read loads the register image
  property p_read_data;
    @(posedge pclk) disable iff (!presetn)
      (pclken && psel && !penable && !pwrite && hit) |=> (prdata[7:1] == {$past(ctrl_q[7:2]), $past(drive_state)});
  endproperty
  a_read_data: assert property (p_read_data) else $error("read image wrong");

  // Upper read bits are always zero
  property p_read_upper;
    @(posedge pclk) disable iff (!presetn)
      prdata[31:8] == 24'h00_0000;
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("upper read bits set");

  // Awake counting is as free as sleeping counting
  property p_awake_count;
    @(posedge pclk) disable iff (!presetn)
      (!sleep_mode && osc_run && osc_rise) |-> osc_count_tick;
  endproperty
  a_awake_count: assert property (p_awake_count) else $error("count lost while awake");

endmodule

// ### tb/csoc_pad_model.sv
`timescale 1ns/1ps
// Sense pad and external timer pin as seen from the block
module csoc_pad_model #(parameter int HALF_NS = 173) (
  // Control
  input wire logic run,
  input wire logic hold,
  // Pad side
  output logic osc,
  output logic pin
);
  // Pad swings only while enabled; hold parks it to expose one level
  initial begin
    osc = 1'b0;
    forever #HALF_NS if (run && !hold) osc <= ~osc;
  end
  // Slower pin, phase unrelated to pclk
  initial begin
    pin = 1'b0;
    forever #(HALF_NS * 3 + 7) pin <= ~pin;
  end
endmodule

// ### tb/cap_sense_osc_control_test.sv
`timescale 1ns/1ps
module cap_sense_osc_control_test;
  logic pclk, presetn, pclken, psel, penable, pwrite, pslverr, pready;
  logic sleep_mode, timer_zero_clock_select, osc, pin, hold, osc_run, ref_mode, noise, t0_tick, osc_tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  csoc_pkg::csoc_cur_e cur;
  int miscompares = 0, checks_done = 0, o, t;
  ////////////////////////////////////////
  csoc_ctrl dut (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_clk_in(osc), .sleep_mode(sleep_mode), .timer_zero_clock_select(timer_zero_clock_select),
    .timer_zero_clock_pin(pin), .osc_run(osc_run), .reference_mode_out(ref_mode), .noise_detect(noise),
    .current_level(cur), .timer_zero_count_tick(t0_tick), .osc_count_tick(osc_tick));
  csoc_pad_model pad (.run(osc_run), .hold(hold), .osc(osc), .pin(pin));
  always #20 pclk = ~pclk;
  ////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits on pready, never assumes its latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(negedge pclk);
  endtask
  // Ticks seen over a fixed window
  task automatic cnt();
    o = 0; t = 0;
    repeat (200) begin
      @(posedge pclk);
      o += osc_tick; t += t0_tick;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    chk({osc_run, ref_mode, noise, cur, t0_tick, osc_tick, pready, pslverr}, 9'h002);
    apb(0, 12'h000, 0); chk(rd, 0);
    apb(0, 12'h004, 0); chk(err, 1);
    chk(rd, 0);
  endtask
  // Every enable, mode and range combination
  task automatic t_modes();
    logic e, m;
    logic [1:0] c;
    for (int i = 0; i < 16; i++) begin
      {e, m, c} = i[3:0];
      apb(1, 12'h000, {e, m, 2'h0, c, 2'h3});
      chk({osc_run, ref_mode, noise, cur}, {e, m, e & m & (c == 0), e ? c : 2'h0});
      apb(0, 12'h000, 0); chk(rd & 32'hfd, {e, m, 2'h0, c, 2'h1});
    end
  endtask
  // Parked pad level shows in the read-only bit
  task automatic t_drive();
    for (int v = 0; v < 2; v++) begin
      apb(1, 12'h000, 32'h82);
      while (osc !== v[0]) @(posedge pclk);
      hold <= 1'b1;
      repeat (5) @(posedge pclk);
      apb(0, 12'h000, 0); chk(rd, {24'h0, 6'h20, osc, 1'b0});
      hold <= 1'b0;
    end
  endtask
  task automatic t_sleep();
    timer_zero_clock_select <= 1'b1;
    apb(1, 12'h000, 32'h81);
    sleep_mode <= 1'b1;
    cnt(); chk(o > 0, 1); chk(t, 0);
    sleep_mode <= 1'b0;
    cnt(); chk(t > 0, 1);
  endtask
  // Timer clock source picks
  task automatic t_pick();
    apb(1, 12'h000, 32'h01); cnt(); chk(t, 0);
    chk(o, 0);
    apb(1, 12'h000, 32'h00); cnt(); chk(t > 0, 1);
    timer_zero_clock_select <= 1'b0;
    apb(1, 12'h000, 32'h81); cnt(); chk(t, 0);
    apb(0, 12'h000, 0); chk(rd & 32'hfd, 32'h81);
  endtask
  ////////////////////////////////////////
  initial begin
    pclk = 0; presetn = 0; pclken = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    sleep_mode = 0; timer_zero_clock_select = 0; hold = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset(); t_modes(); t_drive(); t_sleep(); t_pick();
    tally_and_finish();
  end
  // Hang guard, well past the expected run
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
endmodule
